// ==== hw/asm_auto_shutdown.sv ====
// Purpose: thermal and supply supervision with orderly shutdown request
// Assumes: ms_tick_i pulses once per millisecond; power-on reset on arst_n_i
// Notes:   shutdown_req_o starts the power-down sequence kept elsewhere
`timescale 1ns/1ps
module asm_auto_shutdown #(
	parameter int GUARD_MS      = asm_pkg::GUARD_MS,
	parameter int GSM_FRAME_CYC = asm_pkg::GSM_FRAME_CYC,
	parameter int FRAME10_CYC   = asm_pkg::FRAME10_CYC,
	parameter int PAGE_RX_CYC   = asm_pkg::PAGE_RX_CYC,
	parameter int UV_REPEAT_MS  = asm_pkg::UV_REPEAT_MS,
	parameter int UV_ALERTS     = asm_pkg::UV_ALERTS
) (
	// clock, reset, timebase
	input  wire logic              clk_i,
	input  wire logic              arst_n_i,
	input  wire logic              ms_tick_i,
	// thermal sense resistor reading
	input  wire logic signed [7:0] temp_i,
	input  wire logic              temp_valid_i,
	// main supply rail reading
	input  wire logic [12:0]       supply_mv_i,
	input  wire logic              supply_valid_i,
	// call and network state
	input  wire logic              ecall_active_i,
	input  asm_pkg::asm_rat_t      rat_i,
	input  wire logic [8:0]        drx_i,
	// alert messages
	output asm_pkg::asm_temp_alert_t board_temp_alert_o,
	output asm_pkg::asm_sup_alert_t  supply_condition_alert_o,
	// shutdown and status
	output logic                   shutdown_req_o,
	output asm_pkg::asm_cause_t    shutdown_cause_o,
	output logic                   defer_o,
	output logic                   guard_active_o,
	output asm_pkg::asm_level_t    temp_level_o,
	// power saving
	output logic                   page_rx_o,
	output logic                   sleep_o
);
	localparam int GW = $clog2(GUARD_MS + 1);

	asm_pkg::asm_level_t level;          // current temperature level
	logic                level_chg;      // level moved this cycle
	logic                temp_crit;      // level 2 or -2

	// guard timer
	logic [GW-1:0] guard_q, guard_d;
	logic          guard_run;
	logic          defer;

	// supply tracking
	logic          uv, ov_trip, ov_near;
	logic [15:0]   uv_rep_q, uv_rep_d;   // ms to next repeat
	logic [3:0]    uv_num_q, uv_num_d;   // alerts sent so far
	logic          ovw_done_q, ovw_done_d;
	logic          ovs_done_q, ovs_done_d;
	asm_pkg::asm_sup_alert_t  sup_q, sup_d;
	asm_pkg::asm_temp_alert_t tmp_q, tmp_d;

	// shutdown control
	asm_pkg::asm_state_t state_q, state_d;
	logic                req_q, req_d;
	asm_pkg::asm_cause_t cause_q, cause_d;
	logic                defer_q;
	logic                temp_go, uv_go, ov_go;

	asm_temp_level u_level (
		.clk_i        (clk_i),
		.arst_n_i     (arst_n_i),
		.temp_i       (temp_i),
		.temp_valid_i (temp_valid_i),
		.level_o      (level),
		.change_o     (level_chg)
	);

	asm_paging #(
		.GSM_FRAME_CYC (GSM_FRAME_CYC),
		.FRAME10_CYC   (FRAME10_CYC),
		.PAGE_RX_CYC   (PAGE_RX_CYC)
	) u_paging (
		.clk_i     (clk_i),
		.arst_n_i  (arst_n_i),
		.rat_i     (rat_i),
		.drx_i     (drx_i),
		.page_rx_o (page_rx_o),
		.sleep_o   (sleep_o)
	);

	assign temp_crit = (level == asm_pkg::LVL_P2) || (level == asm_pkg::LVL_N2);

	// guard counts up from reset and stops at its end
	always_comb
	begin
		guard_d = guard_q;
		if (guard_run && ms_tick_i)
			guard_d = guard_q + GW'(1);
	end
	assign guard_run = (guard_q != GW'(GUARD_MS));
	// only the call extends; other traffic does not
	assign defer = guard_run || ecall_active_i;

	// temperature alert: sent even while deferred
	always_comb
	begin
		tmp_d.level = level;
		tmp_d.valid = level_chg && (temp_crit || guard_run);
	end

	// supply comparators, no user enable involved
	assign uv      = supply_valid_i && (supply_mv_i < asm_pkg::UV_MV);
	assign ov_trip = supply_valid_i && (supply_mv_i > asm_pkg::OV_TRIP_MV);
	assign ov_near = supply_valid_i && !ov_trip &&
			(supply_mv_i > asm_pkg::OV_TRIP_MV - asm_pkg::OV_BAND_MV);

	// one supply alert per cycle; losers retry next cycle
	always_comb
	begin
		sup_d      = '0;
		sup_d.kind = asm_pkg::ASM_SUP_UV;
		uv_rep_d   = uv_rep_q;
		uv_num_d   = uv_num_q;
		ovw_done_d = ovw_done_q;
		ovs_done_d = ovs_done_q;
		// repeat timer only runs while undervoltage persists
		if (!uv)
		begin
			uv_rep_d = '0;
			uv_num_d = '0;
		end
		else if (uv_rep_q != '0 && ms_tick_i)
			uv_rep_d = uv_rep_q - 16'h0001;
		if (ov_trip && !ovs_done_q)
		begin
			sup_d.valid = 1'b1;
			sup_d.kind  = asm_pkg::ASM_SUP_OV_SHUT;
			ovs_done_d  = 1'b1;
		end
		else if (uv && uv_rep_q == '0 && uv_num_q != 4'(UV_ALERTS))
		begin
			sup_d.valid = 1'b1;
			sup_d.kind  = asm_pkg::ASM_SUP_UV;
			uv_num_d    = uv_num_q + 4'h1;
			uv_rep_d    = 16'(UV_REPEAT_MS);
		end
		else if (ov_near && !ovw_done_q)
		begin
			sup_d.valid = 1'b1;
			sup_d.kind  = asm_pkg::ASM_SUP_OV_WARN;
			ovw_done_d  = 1'b1;
		end
	end

	assign temp_go = temp_crit && !defer && !level_chg;
	assign uv_go   = uv && uv_num_q == 4'(UV_ALERTS) && uv_rep_q == '0;
	assign ov_go   = ovs_done_q;

	// one request per power cycle, overvoltage first
	always_comb
	begin
		state_d = state_q;
		req_d   = 1'b0;
		cause_d = cause_q;
		unique case (state_q)
			asm_pkg::ASM_ST_RUN:
			begin
				if (ov_go || temp_go || uv_go)
				begin
					state_d = asm_pkg::ASM_ST_DOWN;
					req_d   = 1'b1;
					if (ov_go)
						cause_d = asm_pkg::ASM_CAUSE_OV;
					else if (temp_go)
						cause_d = asm_pkg::ASM_CAUSE_TEMP;
					else
						cause_d = asm_pkg::ASM_CAUSE_UV;
				end
			end
			// power-down underway, only reset leaves
			asm_pkg::ASM_ST_DOWN: state_d = asm_pkg::ASM_ST_DOWN;
		endcase
	end

	// all registers of the block
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			guard_q    <= '0;
			tmp_q      <= '0;
			sup_q      <= '0;
			uv_rep_q   <= '0;
			uv_num_q   <= '0;
			ovw_done_q <= 1'b0;
			ovs_done_q <= 1'b0;
			state_q    <= asm_pkg::ASM_ST_RUN;
			req_q      <= 1'b0;
			cause_q    <= asm_pkg::ASM_CAUSE_NONE;
			defer_q    <= 1'b1;
		end
		else
		begin
			guard_q    <= guard_d;
			tmp_q      <= tmp_d;
			sup_q      <= sup_d;
			uv_rep_q   <= uv_rep_d;
			uv_num_q   <= uv_num_d;
			ovw_done_q <= ovw_done_d;
			ovs_done_q <= ovs_done_d;
			state_q    <= state_d;
			req_q      <= req_d;
			cause_q    <= cause_d;
			defer_q    <= defer;
		end
	end

	assign board_temp_alert_o       = tmp_q;
	assign supply_condition_alert_o = sup_q;
	assign shutdown_req_o           = req_q;
	assign shutdown_cause_o         = cause_q;
	assign defer_o                  = defer_q;
	assign guard_active_o           = guard_run;
	assign temp_level_o             = level;

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	property p_hi2;
		temp_valid_i && temp_i >= asm_pkg::T_HI2_ON && level >= asm_pkg::LVL_Z |=> level == asm_pkg::LVL_P2;
	endproperty
	a_hi2: assert property (p_hi2) else $error("no level 2 at +97");
	property p_hi2_rel;
		temp_valid_i && temp_i <= asm_pkg::T_HI2_OFF && level == asm_pkg::LVL_P2 |=> level == asm_pkg::LVL_P1;
	endproperty
	a_hi2_rel: assert property (p_hi2_rel) else $error("level 2 not released");
	property p_hi1;
		temp_valid_i && temp_i >= asm_pkg::T_HI1_ON && temp_i < asm_pkg::T_HI2_ON && level == asm_pkg::LVL_Z
			|=> level == asm_pkg::LVL_P1;
	endproperty
	a_hi1: assert property (p_hi1) else $error("no level 1 at +86");
	property p_lo1;
		temp_valid_i && temp_i <= asm_pkg::T_LO1_ON && temp_i > asm_pkg::T_LO2_ON && level == asm_pkg::LVL_Z
			|=> level == asm_pkg::LVL_N1;
	endproperty
	a_lo1: assert property (p_lo1) else $error("no level -1 at -31");
	property p_lo2_rel;
		temp_valid_i && temp_i >= asm_pkg::T_LO2_OFF && level == asm_pkg::LVL_N2 |=> level == asm_pkg::LVL_N1;
	endproperty
	a_lo2_rel: assert property (p_lo2_rel) else $error("level -2 not released");
	property p_band;
		temp_valid_i && level == asm_pkg::LVL_P1 && temp_i > asm_pkg::T_HI1_OFF && temp_i < asm_pkg::T_HI2_ON
			|=> $stable(level);
	endproperty
	a_band: assert property (p_band) else $error("level moved in band");
	property p_mild_off;
		level_chg && !temp_crit && !guard_run |=> !board_temp_alert_o.valid;
	endproperty
	a_mild_off: assert property (p_mild_off) else $error("mild alert after guard");
	property p_crit_alert;
		level_chg && temp_crit |=> board_temp_alert_o.valid && board_temp_alert_o.level == $past(level);
	endproperty
	a_crit_alert: assert property (p_crit_alert) else $error("critical alert missing");
	property p_no_defer_shut;
		shutdown_req_o && shutdown_cause_o == asm_pkg::ASM_CAUSE_TEMP |-> !$past(defer);
	endproperty
	a_no_defer_shut: assert property (p_no_defer_shut) else $error("shutdown while deferred");
	property p_resume;
		state_q == asm_pkg::ASM_ST_RUN && temp_crit && !defer && $past(defer) && !level_chg
			|=> shutdown_req_o && !board_temp_alert_o.valid;
	endproperty
	a_resume: assert property (p_resume) else $error("no silent shutdown");
	property p_one_req;
		shutdown_req_o |=> !shutdown_req_o [*8];
	endproperty
	a_one_req: assert property (p_one_req) else $error("repeated shutdown request");
	property p_uv_count;
		shutdown_req_o && shutdown_cause_o == asm_pkg::ASM_CAUSE_UV |-> $past(uv_num_q) == 4'(UV_ALERTS);
	endproperty
	a_uv_count: assert property (p_uv_count) else $error("uv shutdown too early");
	property p_ov_seq;
		supply_condition_alert_o.valid && supply_condition_alert_o.kind == asm_pkg::ASM_SUP_OV_SHUT
			&& state_q == asm_pkg::ASM_ST_RUN |=> shutdown_req_o && shutdown_cause_o == asm_pkg::ASM_CAUSE_OV;
	endproperty
	a_ov_seq: assert property (p_ov_seq) else $error("ov shutdown not after alert");
	property p_call_defer;
		ecall_active_i |=> defer_o;
	endproperty
	a_call_defer: assert property (p_call_defer) else $error("call not deferring");
	property p_guard_end;
		!guard_run |=> !guard_run && guard_active_o == 1'b0;
	endproperty
	a_guard_end: assert property (p_guard_end) else $error("guard restarted");

	c_temp_shut: cover property (shutdown_req_o && shutdown_cause_o == asm_pkg::ASM_CAUSE_TEMP);
	c_ov_shut: cover property (shutdown_req_o && shutdown_cause_o == asm_pkg::ASM_CAUSE_OV);
	c_uv_shut: cover property (shutdown_req_o && shutdown_cause_o == asm_pkg::ASM_CAUSE_UV);
	c_deferred: cover property (temp_crit && defer ##1 !defer);
endmodule : asm_auto_shutdown

// ==== hw/asm_pkg.sv ====
// Purpose: shared types and constants of the auto shutdown monitor
// Assumes: 25 MHz clock, millisecond tick from a free-running timebase
// Notes:   temperatures are whole degC, supply readings are mV
package asm_pkg;
	// clock period in ns
	localparam int CLK_NS = 40;

	// temperature limits, degC
	localparam logic signed [7:0] T_HI2_ON  = 8'sh61;  // +97
	localparam logic signed [7:0] T_HI2_OFF = 8'sh60;  // +96
	localparam logic signed [7:0] T_HI1_ON  = 8'sh56;  // +86
	localparam logic signed [7:0] T_HI1_OFF = 8'sh55;  // +85
	localparam logic signed [7:0] T_LO1_ON  = -8'sh1F; // -31
	localparam logic signed [7:0] T_LO1_OFF = -8'sh1E; // -30
	localparam logic signed [7:0] T_LO2_ON  = -8'sh2A; // -42
	localparam logic signed [7:0] T_LO2_OFF = -8'sh28; // -40

	// signed alert level
	typedef logic signed [2:0] asm_level_t;
	localparam asm_level_t LVL_P2 = 3'sh2;
	localparam asm_level_t LVL_P1 = 3'sh1;
	localparam asm_level_t LVL_Z  = 3'sh0;
	localparam asm_level_t LVL_N1 = -3'sh1;
	localparam asm_level_t LVL_N2 = -3'sh2;

	// guard period after start-up
	localparam int GUARD_MIN = 2;
	localparam int GUARD_MS  = GUARD_MIN * 60 * 1000;

	// paging cycle figures
	localparam int         GSM_FRAME_NS  = 4615000;
	localparam int         GSM_FRAME_CYC = GSM_FRAME_NS / CLK_NS;
	localparam int         GSM_FRAMES    = 51;
	localparam int         FRAME10_MS    = 10;
	localparam int         FRAME10_CYC   = FRAME10_MS * 1000000 / CLK_NS;
	localparam logic [8:0] GSM_DRX_MIN   = 9'h002;
	localparam logic [8:0] GSM_DRX_MAX   = 9'h009;
	localparam logic [8:0] WC_DRX_MIN    = 9'h006;
	localparam logic [8:0] WC_DRX_MAX    = 9'h009;
	localparam logic [8:0] LTE_DRX_MIN   = 9'h020;
	localparam logic [8:0] LTE_DRX_MAX   = 9'h100;
	// paging reception window, least time so rounded up
	localparam int         PAGE_RX_US    = 1000;
	localparam int         PAGE_RX_CYC   = (PAGE_RX_US * 1000 + CLK_NS - 1) / CLK_NS;

	// supply limits, mV
	localparam logic [12:0] VMAX_MV      = 13'h1068;
	localparam logic [12:0] OV_MARGIN_MV = 13'h0064;
	localparam logic [12:0] OV_TRIP_MV   = VMAX_MV + OV_MARGIN_MV;
	localparam logic [12:0] OV_BAND_MV   = 13'h0032;
	localparam logic [12:0] UV_MV        = 13'h0CE4;
	localparam int          UV_REPEAT_MS = 1000;
	localparam int          UV_ALERTS    = 3;

	// radio access mode
	typedef enum logic [1:0] {ASM_RAT_NONE, ASM_RAT_GSM, ASM_RAT_WCDMA, ASM_RAT_LTE} asm_rat_t;
	// supply alert kinds
	typedef enum logic [1:0] {ASM_SUP_UV, ASM_SUP_OV_WARN, ASM_SUP_OV_SHUT} asm_sup_kind_t;
	// shutdown causes
	typedef enum logic [1:0] {ASM_CAUSE_NONE, ASM_CAUSE_TEMP, ASM_CAUSE_UV, ASM_CAUSE_OV} asm_cause_t;
	// top-level states
	typedef enum logic {ASM_ST_RUN, ASM_ST_DOWN} asm_state_t;

	// alert messages
	typedef struct packed {
		logic       valid;
		asm_level_t level;
	} asm_temp_alert_t;
	typedef struct packed {
		logic          valid;
		asm_sup_kind_t kind;
	} asm_sup_alert_t;
endpackage : asm_pkg

// ==== hw/asm_temp_level.sv ====
// Purpose: board temperature to signed alert level with hysteresis
// Assumes: one sample per temp_valid_i
// Notes:   level holds between a limit and its release point
`timescale 1ns/1ps
module asm_temp_level (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              arst_n_i,
	// temperature sample
	input  wire logic signed [7:0] temp_i,
	input  wire logic              temp_valid_i,
	// level out
	output asm_pkg::asm_level_t    level_o,
	output logic                   change_o
);
	asm_pkg::asm_level_t level_q, level_d; // current level
	logic                chg_q, chg_d;     // one-cycle change flag

	// next level, only limit crossings move it
	always_comb
	begin
		level_d = level_q;
		if (temp_valid_i)
		begin
			unique case (level_q)
				asm_pkg::LVL_P2: if (temp_i <= asm_pkg::T_HI2_OFF) level_d = asm_pkg::LVL_P1;
				asm_pkg::LVL_P1:
				begin
					if (temp_i >= asm_pkg::T_HI2_ON) level_d = asm_pkg::LVL_P2;
					else if (temp_i <= asm_pkg::T_HI1_OFF) level_d = asm_pkg::LVL_Z;
				end
				asm_pkg::LVL_Z:
				begin
					if (temp_i >= asm_pkg::T_HI2_ON) level_d = asm_pkg::LVL_P2;
					else if (temp_i >= asm_pkg::T_HI1_ON) level_d = asm_pkg::LVL_P1;
					else if (temp_i <= asm_pkg::T_LO2_ON) level_d = asm_pkg::LVL_N2;
					else if (temp_i <= asm_pkg::T_LO1_ON) level_d = asm_pkg::LVL_N1;
				end
				asm_pkg::LVL_N1:
				begin
					if (temp_i <= asm_pkg::T_LO2_ON) level_d = asm_pkg::LVL_N2;
					else if (temp_i >= asm_pkg::T_LO1_OFF) level_d = asm_pkg::LVL_Z;
				end
				asm_pkg::LVL_N2: if (temp_i >= asm_pkg::T_LO2_OFF) level_d = asm_pkg::LVL_N1;
				// codes 3, -3, -4 cannot occur; recover to normal
				default: level_d = asm_pkg::LVL_Z;
			endcase
		end
		chg_d = (level_d != level_q);
	end

	// level register
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			level_q <= asm_pkg::LVL_Z;
			chg_q   <= 1'b0;
		end
		else
		begin
			level_q <= level_d;
			chg_q   <= chg_d;
		end
	end

	assign level_o  = level_q;
	assign change_o = chg_q;
endmodule : asm_temp_level

// ==== hw/asm_paging.sv ====
// Purpose: paging cycle timer and sleep scheduling
// Assumes: rat_i and drx_i set by the protocol stack
// Notes:   invalid drx keeps the device awake
`timescale 1ns/1ps
module asm_paging #(
	parameter int GSM_FRAME_CYC = asm_pkg::GSM_FRAME_CYC,
	parameter int FRAME10_CYC   = asm_pkg::FRAME10_CYC,
	parameter int PAGE_RX_CYC   = asm_pkg::PAGE_RX_CYC,
	parameter int CW            = 28
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             arst_n_i,
	// network setting
	input  asm_pkg::asm_rat_t     rat_i,
	input  wire logic [8:0]       drx_i,
	// schedule
	output logic                  page_rx_o,
	output logic                  sleep_o
);
	logic [CW-1:0] period;             // paging cycle in clocks
	logic [CW-1:0] phase_q, phase_d;   // position in cycle
	logic          rx_q, rx_d;
	logic          sleep_q, sleep_d;

	// cycle length per access mode
	always_comb
	begin
		period = '0;
		unique case (rat_i)
			asm_pkg::ASM_RAT_GSM:
				if (drx_i >= asm_pkg::GSM_DRX_MIN && drx_i <= asm_pkg::GSM_DRX_MAX)
					period = CW'(32'(drx_i) * asm_pkg::GSM_FRAMES * GSM_FRAME_CYC);
			asm_pkg::ASM_RAT_WCDMA:
				if (drx_i >= asm_pkg::WC_DRX_MIN && drx_i <= asm_pkg::WC_DRX_MAX)
					period = CW'(FRAME10_CYC) << drx_i[3:0];
			asm_pkg::ASM_RAT_LTE:
				if (drx_i >= asm_pkg::LTE_DRX_MIN && drx_i <= asm_pkg::LTE_DRX_MAX && $onehot(drx_i))
					period = CW'(32'(drx_i) * FRAME10_CYC);
			asm_pkg::ASM_RAT_NONE: period = '0;
		endcase
	end

	// phase counter; a shortened cycle wraps at once
	always_comb
	begin
		phase_d = phase_q + CW'(1);
		if (period == '0 || phase_q >= period - CW'(1))
			phase_d = '0;
		rx_d    = (period != '0) && (phase_d < CW'(PAGE_RX_CYC));
		sleep_d = (period != '0) && !rx_d;
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			phase_q <= '0;
			rx_q    <= 1'b0;
			sleep_q <= 1'b0;
		end
		else
		begin
			phase_q <= phase_d;
			rx_q    <= rx_d;
			sleep_q <= sleep_d;
		end
	end

	assign page_rx_o = rx_q;
	assign sleep_o   = sleep_q;

	property p_rx_excl;
		@(posedge clk_i) disable iff (!arst_n_i) sleep_o |-> !page_rx_o;
	endproperty
	a_rx_excl: assert property (p_rx_excl) else $error("sleep while paging");
	c_sleep: cover property (@(posedge clk_i) disable iff (!arst_n_i) $rose(sleep_o));
endmodule : asm_paging

// ==== tb/asm_host_model.sv ====
// Purpose: host side sink for unsolicited alert messages
// Assumes: each message is a one-cycle valid pulse
// Notes:   only counts messages; their order is judged by the bench queue
`timescale 1ns/1ps
module asm_host_model (
	// clock
	input  wire logic                clk_i,
	// messages from the device
	input  asm_pkg::asm_temp_alert_t temp_msg_i,
	input  asm_pkg::asm_sup_alert_t  sup_msg_i,
	// number of messages taken
	output int                       n_msg_o
);
	// the host never stalls, so a message is taken in its own cycle
	// running count, given its start value at declaration so one process drives it
	int cnt = 0;

	// count every message of either kind
	always @(posedge clk_i)
	begin
		cnt <= cnt + int'(temp_msg_i.valid === 1'b1) + int'(sup_msg_i.valid === 1'b1);
	end

	assign n_msg_o = cnt;
endmodule : asm_host_model

// ==== tb/asm_auto_shutdown_tb_top.sv ====
// Purpose: self-checking bench for the auto shutdown monitor
// Assumes: shortened guard, frame and repeat counts
// Notes:   events are noted in a queue and matched in order by a monitor
`timescale 1ns/1ps
module asm_auto_shutdown_tb_top;
	// shortened counts, ticks every 4 cycles
	localparam int GUARD = 20;
	localparam int GFR   = 3;
	localparam int F10   = 2;
	localparam int PRX   = 2;
	localparam int UVR   = 3;
	// stimulus
	logic                     clk_i          = 1'b0;
	logic                     arst_n_i;
	logic                     ms_tick_i      = 1'b0;
	logic signed [7:0]        temp_i;
	logic                     temp_valid_i;
	logic [12:0]              supply_mv_i;
	logic                     supply_valid_i;
	logic                     ecall_active_i;
	asm_pkg::asm_rat_t        rat_i;
	logic [8:0]               drx_i;
	// observed
	asm_pkg::asm_temp_alert_t board_temp_alert_o;
	asm_pkg::asm_sup_alert_t  supply_condition_alert_o;
	logic                     shutdown_req_o;
	asm_pkg::asm_cause_t      shutdown_cause_o;
	logic                     defer_o;
	logic                     guard_active_o;
	asm_pkg::asm_level_t      temp_level_o;
	logic                     page_rx_o;
	logic                     sleep_o;
	int                       n_msg;
	// bookkeeping
	logic [4:0]               expq [$];
	int                       failures       = 0;
	int                       n_tests        = 0;
	int                       n_exp          = 0;
	int                       seed           = 69085;
	logic [1:0]               tk             = 2'h0;
	int                       tt [12]        = '{86, 96, 97, 96, 90, 85, -31, -40, -42, -41, -40, -30};
	int                       lt [12]        = '{1, 1, 2, 1, 1, 0, -1, -1, -2, -2, -1, 0};
	int                       i, m, per, gk;
	logic [8:0]               d;

	asm_auto_shutdown #(.GUARD_MS(GUARD), .GSM_FRAME_CYC(GFR), .FRAME10_CYC(F10), .PAGE_RX_CYC(PRX),
		.UV_REPEAT_MS(UVR), .UV_ALERTS(3)) asm_auto_shutdown_i (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .ms_tick_i(ms_tick_i), .temp_i(temp_i),
		.temp_valid_i(temp_valid_i), .supply_mv_i(supply_mv_i), .supply_valid_i(supply_valid_i),
		.ecall_active_i(ecall_active_i), .rat_i(rat_i), .drx_i(drx_i),
		.board_temp_alert_o(board_temp_alert_o), .supply_condition_alert_o(supply_condition_alert_o),
		.shutdown_req_o(shutdown_req_o), .shutdown_cause_o(shutdown_cause_o), .defer_o(defer_o),
		.guard_active_o(guard_active_o), .temp_level_o(temp_level_o), .page_rx_o(page_rx_o),
		.sleep_o(sleep_o));

	asm_host_model asm_host_model_i (.clk_i(clk_i), .temp_msg_i(board_temp_alert_o),
		.sup_msg_i(supply_condition_alert_o), .n_msg_o(n_msg));

	// 25 MHz clock
	always #20 clk_i = ~clk_i;

	// millisecond tick, one pulse every 4 cycles
	always @(posedge clk_i)
	begin
		#2;
		tk = tk + 2'h1;
		ms_tick_i = (tk == 2'h0);
	end

	// monitor: every result takes the oldest note, in a fixed order
	always @(negedge clk_i)
	begin
		if (board_temp_alert_o.valid === 1'b1) take({2'h1, board_temp_alert_o.level});
		if (supply_condition_alert_o.valid === 1'b1) take({2'h2, 1'b0, supply_condition_alert_o.kind});
		if (shutdown_req_o === 1'b1) take({2'h3, 1'b0, shutdown_cause_o});
	end

	task chk(input string nm, input logic [15:0] seen, input logic [15:0] expv);
		n_tests++;
		if (seen !== expv)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, expv, seen);
		end
	endtask : chk

	// an empty queue yields a code that no real event carries
	task take(input logic [4:0] v);
		logic [4:0] e;
		e = (expq.size() != 0) ? expq.pop_front() : 5'h00;
		chk("event", {11'h000, v}, {11'h000, e});
	endtask : take

	// note an expected event; supply and temp alerts reach the host
	task note(input logic [4:0] v);
		expq.push_back(v);
		if (v[4:3] != 2'h3) n_exp++;
	endtask : note

	// move to just after the nth rising edge
	task step(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask : step

	task rst();
		chk("left", 16'(expq.size()), 16'h0000);
		arst_n_i = 1'b0;
		step(16);
		arst_n_i = 1'b1;
		step(1);
	endtask : rst

	// one temperature sample, then room for the alert
	task smp(input int t);
		temp_i = 8'(t);
		temp_valid_i = 1'b1;
		step(1);
		temp_valid_i = 1'b0;
		step(3);
	endtask : smp

	// bounded wait for the end of the guard period
	task wait_guard(output int k);
		for (k = 0; k < 400 && guard_active_o !== 1'b0; k++) step(1);
		step(2);
		chk("defer", {15'h0000, defer_o}, {15'h0000, ecall_active_i});
	endtask : wait_guard

	// bounded wait until all noted events were seen
	task drain(input int n);
		for (int k = 0; k < n && expq.size() != 0; k++) step(1);
		chk("pending", 16'(expq.size()), 16'h0000);
	endtask : drain

	// measure one paging cycle from rise to rise
	task pg(input int pr);
		int n, hi, sl;
		logic pw;
		pw = 1'b1;
		step(2);
		for (n = 0; n < 3000 && !(page_rx_o === 1'b1 && pw === 1'b0); n++)
		begin
			pw = page_rx_o;
			step(1);
		end
		n = 0;
		hi = 0;
		sl = 0;
		do
		begin
			hi += int'(page_rx_o === 1'b1);
			sl += int'(sleep_o === 1'b1);
			pw = page_rx_o;
			step(1);
			n++;
		end while (n < 3000 && !(page_rx_o === 1'b1 && pw === 1'b0));
		chk("period", 16'(n), 16'(pr));
		chk("rx_len", 16'(hi), 16'(PRX));
		chk("sleep_len", 16'(sl), 16'(pr - PRX));
	endtask : pg

	task end_sim();
		chk("host_msgs", 16'(n_msg), 16'(n_exp));
		$display("TB: checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim

	// watchdog against a hang
	initial
	begin
		#(40 * 60000);
		failures++;
		end_sim();
	end

	initial
	begin
		arst_n_i = 1'b0;
		temp_i = 8'sh19;
		temp_valid_i = 1'b0;
		supply_mv_i = 13'h0ED8;
		supply_valid_i = 1'b0;
		ecall_active_i = 1'b0;
		rat_i = asm_pkg::ASM_RAT_NONE;
		drx_i = 9'h000;
		rst();
		// hysteresis walk inside the guard, every change alerted
		for (i = 0; i < 12; i++)
		begin
			if (i == 0 || lt[i] != lt[i - 1]) note({2'h1, 3'(lt[i])});
			smp(tt[i]);
			chk("level", {13'h0000, temp_level_o}, {13'h0000, 3'(lt[i])});
		end
		// call starts in guard: alert, but no shutdown
		ecall_active_i = 1'b1;
		note({2'h1, 3'h2});
		smp(100);
		wait_guard(gk);
		step(10);
		// call ends while still hot: shutdown without alert
		note({2'h3, 3'h1});
		ecall_active_i = 1'b0;
		drain(10);
		chk("cause", {14'h0000, shutdown_cause_o}, 16'h0001);
		// after guard: level 1 silent, level -2 alerts and shuts down
		rst();
		wait_guard(gk);
		chk("guard_len", 16'(gk >= 72 && gk <= 84), 16'h0001);
		smp(86);
		chk("level", {13'h0000, temp_level_o}, 16'h0001);
		smp(85);
		note({2'h1, 3'h6});
		note({2'h3, 3'h1});
		smp(-42);
		drain(10);
		// overvoltage: warn once, then shutdown alert and shutdown
		rst();
		supply_valid_i = 1'b1;
		supply_mv_i = 13'(3300 + {$random(seed)} % 950);
		step(4);
		note({2'h2, 3'h1});
		supply_mv_i = 13'd4260;
		step(5);
		supply_mv_i = 13'd4290;
		step(5);
		note({2'h2, 3'h2});
		note({2'h3, 3'h3});
		supply_mv_i = 13'd4400;
		drain(10);
		supply_mv_i = 13'h0ED8;
		// undervoltage: repeated alerts, then shutdown
		rst();
		repeat (3) note({2'h2, 3'h0});
		note({2'h3, 3'h2});
		supply_mv_i = 13'd3200;
		drain(150);
		supply_mv_i = 13'h0ED8;
		// paging cycles for random modes and drx values
		rst();
		repeat (5)
		begin
			m = {$random(seed)} % 3;
			i = {$random(seed)} % 4;
			if (m == 0)
			begin
				d = 9'(2 + {$random(seed)} % 8);
				rat_i = asm_pkg::ASM_RAT_GSM;
				per = int'(d) * 51 * GFR;
			end
			else if (m == 1)
			begin
				d = 9'(6 + i);
				rat_i = asm_pkg::ASM_RAT_WCDMA;
				per = F10 << d;
			end
			else
			begin
				d = 9'(32 << i);
				rat_i = asm_pkg::ASM_RAT_LTE;
				per = int'(d) * F10;
			end
			drx_i = d;
			pg(per);
		end
		// a drx value outside the set keeps the device awake
		drx_i = 9'h021;
		step(6);
		chk("awake", {14'h0000, page_rx_o, sleep_o}, 16'h0000);
		end_sim();
	end
endmodule : asm_auto_shutdown_tb_top
